// ---- rtl/rtc_pf_pkg.sv ----
/*
 * Constants for the real-time clock output block: register map, field positions,
 * reset values and divider sizes.
 * Assumes a 32-bit Avalon-MM slave with byte addresses and word registers.
 */
package rtc_pf_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [3:0] OFS_CTRL_A = 4'h0;
	localparam logic [3:0] OFS_CTRL_B = 4'h4;
	localparam logic [3:0] OFS_EXT = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;
	localparam int ADDR_W = 4;
	// ==========================================================
	// Field positions
	localparam int RATE_W = 4;
	localparam int RATE_LSB = 0;
	localparam int SQ_EN_BIT = 3;
	localparam int KEEP_32K_BIT = 0;
	localparam int AUX_EN_BIT = 1;
	localparam int WAKE_EN_BIT = 2;
	localparam int KICK_EN_BIT = 3;
	localparam int REQ_BIT = 4;
	localparam int KICK_FLAG_BIT = 5;
	localparam int WAKE_FLAG_BIT = 6;
	localparam int ST_VALID_BIT = 0;
	localparam int ST_AUX_BIT = 1;
	// ==========================================================
	// Reset values
	localparam logic [3:0] RATE_RST = 4'h0;
	localparam logic SQ_EN_RST = 1'b0;
	localparam logic [3:0] EXT_EN_RST = 4'h0;
	// ==========================================================
	// Divider chain
	localparam int DIV_STAGES = 15;
	localparam int TAP_COUNT = 13;
	localparam int TAP_OFFSET = 2;
	localparam logic [3:0] RATE_FIRST_TAP = 4'h3;
	localparam logic [3:0] RATE_ALIAS_1 = 4'h1;
	localparam logic [3:0] RATE_ALIAS_2 = 4'h2;
	localparam logic [3:0] ALIAS_SHIFT = 4'h7;
endpackage : rtc_pf_pkg

// ---- rtl/pin_sync.sv ----
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes inputs are asynchronous to clk; reset level is a parameter.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : pin_sync

// ---- rtl/rtc_power_fail_outputs.sv ----
/*
 * Output side of a battery-backed real-time clock: square-wave tap select,
 * always-on 32kHz option, external RAM chip-enable gating and power-on request.
 * Assumes a 32.768kHz oscillator square wave on osc_in, a supply comparator
 * level on power_fail_trip (high = above trip point) and an Avalon-MM master.
 */
`timescale 1ns/1ps

// Functional notes
// - The square-wave output comes from one of 13 taps of a 15-stage divider chain.
// - Register A rate picks the tap and the enable bit in register B turns it on or off.
// - 32kHz goes out when square-wave enable, 32kHz enable and valid supply are all set.
// - 32kHz keeps running on a failed supply if 32kHz enable, aux enable and aux battery hold.
// - With valid supply the RAM chip-enable output follows the chip-enable input.
// - With invalid supply the RAM chip-enable output is held high.
// - A kickstart event or a wake-up alarm asserts the active-low power-on request.
// - Software can release the power-on request to shut system power down.
// - On failed supply bus accesses are ignored and registers write-protected.
// - Kickstart works only with aux enable set and aux battery present.
module rtc_power_fail_outputs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [rtc_pf_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Oscillator and supply status pins
	input wire logic osc_in,
	input wire logic power_fail_trip,
	input wire logic aux_battery_supply,
	// Wake-up alarm pulse from the alarm logic on clk
	input wire logic wake_alarm,
	// External pins
	input wire logic kickstart_in_n,
	input wire logic ram_enable_in_n,
	output logic ram_enable_out_n,
	output logic power_on_request_n,
	output logic square_wave_out
);
	// ==========================================================
	// Pin synchronisers
	logic osc_s, power_valid, aux_present, kick_s_n, ram_in_s_n;

	pin_sync #(.WIDTH(5), .RST_VAL(5'h18)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({kickstart_in_n, ram_enable_in_n, osc_in, power_fail_trip, aux_battery_supply}),
		.q({kick_s_n, ram_in_s_n, osc_s, power_valid, aux_present})
	);

	// ==========================================================
	// Registers
	logic [rtc_pf_pkg::RATE_W-1:0] rate;
	logic square_wave_enable;
	logic always_on_32khz_enable, aux_battery_enable, wake_enable, kick_enable;
	logic request, kick_flag, wake_flag;
	logic bus_req, bus_write_now, ext_write;

	assign bus_req = read | write;
	assign bus_write_now = write && !waitrequest && byteenable[0] && power_valid;
	assign ext_write = bus_write_now && address == rtc_pf_pkg::OFS_EXT;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rate <= rtc_pf_pkg::RATE_RST;
			square_wave_enable <= rtc_pf_pkg::SQ_EN_RST;
		end else if (bus_write_now) begin
			if (address == rtc_pf_pkg::OFS_CTRL_A)
				rate <= writedata[rtc_pf_pkg::RATE_LSB +: rtc_pf_pkg::RATE_W];
			if (address == rtc_pf_pkg::OFS_CTRL_B)
				square_wave_enable <= writedata[rtc_pf_pkg::SQ_EN_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{kick_enable, wake_enable, aux_battery_enable, always_on_32khz_enable} <=
				rtc_pf_pkg::EXT_EN_RST;
		end else if (ext_write) begin
			always_on_32khz_enable <= writedata[rtc_pf_pkg::KEEP_32K_BIT];
			aux_battery_enable <= writedata[rtc_pf_pkg::AUX_EN_BIT];
			wake_enable <= writedata[rtc_pf_pkg::WAKE_EN_BIT];
			kick_enable <= writedata[rtc_pf_pkg::KICK_EN_BIT];
		end
	end

	// ==========================================================
	// Avalon-MM handshake: one wait cycle, then one ready cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			waitrequest <= 1'b1;
		else
			waitrequest <= !(bus_req && waitrequest);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			readdata <= 32'h0000_0000;
			if (power_valid) begin
				unique case (address)
					rtc_pf_pkg::OFS_CTRL_A:
						readdata[rtc_pf_pkg::RATE_LSB +: rtc_pf_pkg::RATE_W] <= rate;
					rtc_pf_pkg::OFS_CTRL_B:
						readdata[rtc_pf_pkg::SQ_EN_BIT] <= square_wave_enable;
					rtc_pf_pkg::OFS_EXT: begin
						readdata[rtc_pf_pkg::KEEP_32K_BIT] <= always_on_32khz_enable;
						readdata[rtc_pf_pkg::AUX_EN_BIT] <= aux_battery_enable;
						readdata[rtc_pf_pkg::WAKE_EN_BIT] <= wake_enable;
						readdata[rtc_pf_pkg::KICK_EN_BIT] <= kick_enable;
						readdata[rtc_pf_pkg::REQ_BIT] <= request;
						readdata[rtc_pf_pkg::KICK_FLAG_BIT] <= kick_flag;
						readdata[rtc_pf_pkg::WAKE_FLAG_BIT] <= wake_flag;
					end
					rtc_pf_pkg::OFS_STATUS: begin
						readdata[rtc_pf_pkg::ST_VALID_BIT] <= power_valid;
						readdata[rtc_pf_pkg::ST_AUX_BIT] <= aux_present;
					end
					default: readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// Power-on request
	logic kick_prev_n, kick_event, wake_event, release_req;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			kick_prev_n <= 1'b1;
		else
			kick_prev_n <= kick_s_n;
	end

	assign kick_event = kick_prev_n && !kick_s_n && kick_enable &&
		aux_battery_enable && aux_present;
	assign wake_event = wake_alarm && wake_enable;
	assign release_req = ext_write && writedata[rtc_pf_pkg::REQ_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			request <= 1'b0;
			kick_flag <= 1'b0;
			wake_flag <= 1'b0;
		end else begin
			// Set wins over a write-one-to-clear in the same cycle
			request <= kick_event || wake_event || (request && !release_req);
			kick_flag <= kick_event ||
				(kick_flag && !(ext_write && writedata[rtc_pf_pkg::KICK_FLAG_BIT]));
			wake_flag <= wake_event ||
				(wake_flag && !(ext_write && writedata[rtc_pf_pkg::WAKE_FLAG_BIT]));
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			power_on_request_n <= 1'b1;
		else
			power_on_request_n <= !(kick_event || wake_event || (request && !release_req));
	end

	// ==========================================================
	// RAM chip-enable gating
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ram_enable_out_n <= 1'b1;
		else if (power_valid)
			ram_enable_out_n <= ram_in_s_n;
		else
			ram_enable_out_n <= 1'b1;
	end

	// ==========================================================
	// Divider chain, clocked by oscillator rising-edge enable
	logic osc_prev, osc_tick;
	logic [rtc_pf_pkg::DIV_STAGES-1:0] div;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			osc_prev <= 1'b0;
		else
			osc_prev <= osc_s;
	end

	assign osc_tick = osc_s && !osc_prev;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			div <= '0;
		else if (osc_tick)
			div <= div + 1'b1;
	end

	// ==========================================================
	// Square-wave selection
	logic [3:0] tap_rate;
	logic tap_out, keep_32k, next_square;

	always_comb begin
		tap_rate = rate;
		if (rate == rtc_pf_pkg::RATE_ALIAS_1 || rate == rtc_pf_pkg::RATE_ALIAS_2)
			tap_rate = rate + rtc_pf_pkg::ALIAS_SHIFT;
		tap_out = 1'b0;
		if (tap_rate >= rtc_pf_pkg::RATE_FIRST_TAP)
			tap_out = div[tap_rate - 4'(rtc_pf_pkg::TAP_OFFSET)];
	end

	assign keep_32k = always_on_32khz_enable &&
		((square_wave_enable && power_valid) ||
		(!power_valid && aux_battery_enable && aux_present));

	always_comb begin
		if (keep_32k)
			next_square = osc_s;
		else if (square_wave_enable && power_valid)
			next_square = tap_out;
		else
			next_square = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			square_wave_out <= 1'b0;
		else
			square_wave_out <= next_square;
	end
endmodule : rtc_power_fail_outputs

// ---- tb/rtc_far_side.sv ----
/* Far-side oscillator for the output block.
   Free-running, unrelated to clk. */
`timescale 1ns/1ps
module rtc_far_side (
	output logic osc_in
);
	initial begin
		osc_in = 1'b0;
		forever #61 osc_in = ~osc_in;
	end
endmodule : rtc_far_side

// ---- tb/rtc_pf_assertions.sv ----
/* Port checker for rtc_power_fail_outputs.
   Bound to every instance of the top module. */
`timescale 1ns/1ps
module rtc_pf_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [rtc_pf_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic power_fail_trip,
	input wire logic aux_battery_supply,
	input wire logic wake_alarm,
	input wire logic kickstart_in_n,
	input wire logic ram_enable_in_n,
	input wire logic ram_enable_out_n,
	input wire logic power_on_request_n,
	input wire logic square_wave_out
);
	// ==========
	// Helpers
	logic [3:0] up;
	wire rel = write && !waitrequest && address == rtc_pf_pkg::OFS_EXT &&
		writedata[rtc_pf_pkg::REQ_BIT] && byteenable[0];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) up <= 4'h0;
		else if (up != 4'hF) up <= up + 4'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_ce_follow: assert property (power_fail_trip[*6] ##0 (up == 4'hF) |->
		ram_enable_out_n == $past(ram_enable_in_n, 3)) else $error("ce follow");
	chk_ce_block: assert property ((!power_fail_trip)[*4] |-> ram_enable_out_n)
		else $error("ce block");
	chk_req_hold: assert property (!power_on_request_n && !rel |=> !power_on_request_n)
		else $error("req hold");
	chk_req_release: assert property ((power_fail_trip && kickstart_in_n)[*5] ##0
		(rel && !wake_alarm) |=> power_on_request_n || wake_alarm) else $error("release");
	chk_wait_low: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("wait low");
	chk_wait_once: assert property (!waitrequest |=> waitrequest)
		else $error("wait once");
	chk_read_zero: assert property ((!power_fail_trip)[*4] ##0 (read && !waitrequest)
		|-> readdata == 32'h0) else $error("read zero");
	chk_square_dead: assert property ((!power_fail_trip && !aux_battery_supply)[*6]
		|-> !square_wave_out) else $error("square wave dead");
endmodule : rtc_pf_checker
bind rtc_power_fail_outputs rtc_pf_checker chk_u (.clk, .rst_n, .address, .read, .write,
	.writedata, .byteenable, .readdata, .waitrequest, .power_fail_trip, .aux_battery_supply,
	.wake_alarm, .kickstart_in_n, .ram_enable_in_n, .ram_enable_out_n, .power_on_request_n,
	.square_wave_out);

// ---- tb/rtc_power_fail_outputs_tb.sv ----
/* Self-checking bench for rtc_power_fail_outputs.
   Assumes the far-side model supplies osc_in. */
`timescale 1ns/1ps
module rtc_power_fail_outputs_tb;
	// ==========
	// Signals
	logic clk, rst_n, read, write, waitrequest, power_fail_trip, aux_battery_supply;
	logic wake_alarm, kickstart_in_n, ram_enable_in_n, ram_enable_out_n, osc_in;
	logic power_on_request_n, square_wave_out;
	logic [3:0] address, byteenable;
	logic [31:0] writedata, readdata, v;
	logic [31:0] exq[$];
	int mismatches = 0;
	int cmp_count = 0;
	int seed = 32'h0B7E;
	rtc_far_side far_u (.osc_in);
	rtc_power_fail_outputs dut_u (.clk, .rst_n, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .osc_in, .power_fail_trip,
		.aux_battery_supply, .wake_alarm, .kickstart_in_n, .ram_enable_in_n,
		.ram_enable_out_n, .power_on_request_n, .square_wave_out);
	// ==========
	// Tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task report_and_stop;
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		address <= a;
		writedata <= d;
		byteenable <= be;
		read <= ~w;
		write <= w;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task rd(input logic [3:0] a, input logic [31:0] e);
		exq.push_back(e);
		bus(1'b0, a, 32'h0, 4'hF);
	endtask : rd
	task wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr
	task square_edges(input int e);
		int c;
		logic p;
		c = 0;
		repeat (8) @(posedge clk);
		p = square_wave_out;
		repeat (256) begin
			@(posedge clk);
			if (square_wave_out !== p) c++;
			p = square_wave_out;
		end
		chk({31'h0, c >= e - 1 && c <= e + 1}, 32'h1);
	endtask : square_edges
	always @(posedge clk) begin
		if (read && !waitrequest) chk(readdata, exq.pop_front());
	end
	// ==========
	// Sequence
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#1000000;
		mismatches++;
		report_and_stop;
	end
	initial begin
		{rst_n, read, write, wake_alarm, address, byteenable, writedata} = '0;
		{power_fail_trip, aux_battery_supply, kickstart_in_n, ram_enable_in_n} = 4'hF;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(rtc_pf_pkg::OFS_EXT, 32'h0);
		rd(rtc_pf_pkg::OFS_STATUS, 32'h3);
		rd(4'h1, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = 32'($random(seed)) & 32'hF;
			wr(rtc_pf_pkg::OFS_CTRL_A, v);
			rd(rtc_pf_pkg::OFS_CTRL_A, v);
		end
		bus(1'b1, rtc_pf_pkg::OFS_CTRL_A, ~v, 4'h0);
		rd(rtc_pf_pkg::OFS_CTRL_A, v);
		for (int i = 0; i < 6; i++) begin
			ram_enable_in_n <= 1'($random(seed));
			repeat (4) @(posedge clk);
			chk({31'h0, ram_enable_out_n}, {31'h0, ram_enable_in_n});
		end
		wr(rtc_pf_pkg::OFS_EXT, 32'h0A);
		ram_enable_in_n <= 1'b0;
		power_fail_trip <= 1'b0;
		repeat (5) @(posedge clk);
		chk({31'h0, ram_enable_out_n}, 32'h1);
		wr(rtc_pf_pkg::OFS_CTRL_A, ~v);
		rd(rtc_pf_pkg::OFS_STATUS, 32'h0);
		kickstart_in_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk({31'h0, power_on_request_n}, 32'h0);
		kickstart_in_n <= 1'b1;
		power_fail_trip <= 1'b1;
		repeat (4) @(posedge clk);
		rd(rtc_pf_pkg::OFS_CTRL_A, v);
		wr(rtc_pf_pkg::OFS_EXT, 32'h1A);
		repeat (2) @(posedge clk);
		chk({31'h0, power_on_request_n}, 32'h1);
		wr(rtc_pf_pkg::OFS_EXT, 32'h08);
		kickstart_in_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk({31'h0, power_on_request_n}, 32'h1);
		kickstart_in_n <= 1'b1;
		wr(rtc_pf_pkg::OFS_EXT, 32'h04);
		wake_alarm <= 1'b1;
		@(posedge clk);
		wake_alarm <= 1'b0;
		repeat (2) @(posedge clk);
		chk({31'h0, power_on_request_n}, 32'h0);
		rd(rtc_pf_pkg::OFS_EXT, 32'h74);
		wr(rtc_pf_pkg::OFS_EXT, 32'h74);
		repeat (2) @(posedge clk);
		chk({31'h0, power_on_request_n}, 32'h1);
		rd(rtc_pf_pkg::OFS_EXT, 32'h04);
		wr(rtc_pf_pkg::OFS_CTRL_B, 32'h8);
		rd(rtc_pf_pkg::OFS_CTRL_B, 32'h8);
		for (int r = 3; r < 7; r++) begin
			wr(rtc_pf_pkg::OFS_CTRL_A, 32'(r));
			square_edges(6400 / (61 << (r - 1)));
		end
		wr(rtc_pf_pkg::OFS_CTRL_A, 32'h0);
		square_edges(0);
		wr(rtc_pf_pkg::OFS_CTRL_A, 32'h3);
		wr(rtc_pf_pkg::OFS_CTRL_B, 32'h0);
		square_edges(0);
		wr(rtc_pf_pkg::OFS_CTRL_B, 32'h8);
		wr(rtc_pf_pkg::OFS_EXT, 32'h3);
		square_edges(104);
		power_fail_trip <= 1'b0;
		square_edges(104);
		aux_battery_supply <= 1'b0;
		square_edges(0);
		report_and_stop;
	end
endmodule : rtc_power_fail_outputs_tb
